// File: pkg/adps_cnt_if.sv
// Interface between the sequencer and its cycle timer
`default_nettype none
interface adps_cnt_if;
    logic load;
    logic [3:0] value;
    logic done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface : adps_cnt_if
`default_nettype wire

// File: pkg/adps_defines.svh
// Timing counts and field widths for the dual-port memory host controller
`ifndef ADPS_DEFINES_SVH
`define ADPS_DEFINES_SVH
`define ADPS_CLK_PERIOD_NS 40
`define ADPS_ADDR_W 12
`define ADPS_DATA_W 8
// Fastest-grade timing figures in ns
`define ADPS_T_RC_NS 20
`define ADPS_T_WP_NS 15
`define ADPS_T_WZ_NS 15
`define ADPS_T_DW_NS 15
`define ADPS_T_AA_NS 20
`define ADPS_T_WDD_NS 40
`define ADPS_DATA_TO_PEER_DATA_DELAY_NS 30
`define ADPS_DESELECT_BEFORE_RETENTION_NS 0
// Least times round up, never below one cycle
`define ADPS_CYC_UP(ns) ((((ns) + `ADPS_CLK_PERIOD_NS - 1) / `ADPS_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ADPS_CLK_PERIOD_NS - 1) / `ADPS_CLK_PERIOD_NS))
`define ADPS_RD_CYC `ADPS_CYC_UP(`ADPS_T_RC_NS)
`define ADPS_WP_CYC `ADPS_CYC_UP(`ADPS_T_WZ_NS + `ADPS_T_DW_NS)
`define ADPS_XP_CYC `ADPS_CYC_UP(`ADPS_T_WDD_NS)
`define ADPS_REC_CYC `ADPS_CYC_UP(`ADPS_T_RC_NS)
`endif

// File: pkg/adps_pkg.sv
// Types for the dual-port memory host controller
`default_nettype none
package adps_pkg;
    typedef enum logic [5:0] {
        ADPS_IDLE = 6'h01,
        ADPS_RD = 6'h02,
        ADPS_WR_SET = 6'h04,
        ADPS_WR = 6'h08,
        ADPS_WR_END = 6'h10,
        ADPS_RET = 6'h20
    } adps_state_e;
endpackage : adps_pkg
`default_nettype wire

// File: rtl/adps_host.sv
// Host controller driving one port of an asynchronous dual-port memory
`include "adps_defines.svh"
`default_nettype none
module adps_host
    import adps_pkg::*;
#(
    parameter int ADDR_W = `ADPS_ADDR_W,
    parameter int DATA_W = `ADPS_DATA_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic retain_req,
    output logic retain_active,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic mem_sel_n,
    output logic mem_rd_wr_n,
    output logic mem_oe_n,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] port_data_bus_in,
    output logic [DATA_W-1:0] port_data_bus_out,
    output logic port_data_bus_oe_n
);
    adps_state_e state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r, rdata_r;
    logic [DATA_W-1:0] din_s1_r, din_s2_r;
    logic rsp_r, rec_r, rec_nxt;
    adps_cnt_if cnt ();

    adps_timer u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .cnt(cnt)
    );

    // Read data crosses from the pins; two flops before use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= port_data_bus_in;
            din_s2_r <= din_s1_r;
        end
    end

    // Phase decode as named wires
    wire is_idle = (state_r == ADPS_IDLE);
    wire take = is_idle && req_valid && !retain_req && !rec_r && cnt.done;
    wire go_ret = is_idle && retain_req && cnt.done;
    wire phase_end = cnt.done;

    // Next state: writes are a setup, a pulse and a recovery phase
    always_comb begin
        state_nxt = state_r;
        rec_nxt = rec_r;
        cnt.load = 1'b0;
        cnt.value = 4'h0;
        case (state_r)
            ADPS_IDLE: begin
                if (go_ret) begin
                    state_nxt = ADPS_RET;
                end else if (take && req_write) begin
                    state_nxt = ADPS_WR_SET;
                    cnt.load = 1'b1;
                    cnt.value = 4'h1;
                end else if (take) begin
                    state_nxt = ADPS_RD;
                    cnt.load = 1'b1;
                    cnt.value = 4'((`ADPS_RD_CYC) + 2);
                end else if (rec_r && cnt.done) begin
                    rec_nxt = 1'b0;
                end
            end
            ADPS_RD: begin
                if (phase_end) begin
                    state_nxt = ADPS_IDLE;
                end
            end
            ADPS_WR_SET: begin
                if (phase_end) begin
                    state_nxt = ADPS_WR;
                    cnt.load = 1'b1;
                    cnt.value = 4'(`ADPS_WP_CYC);
                end
            end
            ADPS_WR: begin
                if (phase_end) begin
                    state_nxt = ADPS_WR_END;
                    cnt.load = 1'b1;
                    cnt.value = 4'(`ADPS_XP_CYC);
                end
            end
            ADPS_WR_END: begin
                if (phase_end) begin
                    state_nxt = ADPS_IDLE;
                end
            end
            ADPS_RET: begin
                if (!retain_req) begin
                    state_nxt = ADPS_IDLE;
                    rec_nxt = 1'b1;
                    cnt.load = 1'b1;
                    cnt.value = 4'(`ADPS_REC_CYC);
                end
            end
            default: begin
                state_nxt = ADPS_IDLE;
            end
        endcase
    end

    // Latch the request so pins hold steady through the cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ADPS_IDLE;
            rec_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            rec_r <= rec_nxt;
            if (take) begin
                addr_r <= req_addr;
                wdata_r <= req_wdata;
            end
        end
    end

    // Capture read data at the end of the read phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
            rsp_r <= 1'b0;
        end else begin
            rsp_r <= (state_r == ADPS_RD) && phase_end;
            if ((state_r == ADPS_RD) && phase_end) begin
                rdata_r <= din_s2_r;
            end
        end
    end

    // Pin decode; address only moves in idle with direction high
    wire in_wr = (state_r == ADPS_WR);
    wire in_rd = (state_r == ADPS_RD);
    wire in_wcyc = (state_r == ADPS_WR_SET) || in_wr || (state_r == ADPS_WR_END);
    assign mem_sel_n = !(in_rd || in_wr);
    assign mem_rd_wr_n = !in_wcyc;
    assign mem_oe_n = !in_rd;
    assign mem_addr = addr_r;
    // Drive data only while the device's outputs are off
    assign port_data_bus_oe_n = !in_wr;
    assign port_data_bus_out = wdata_r;
    assign req_ready = is_idle && !retain_req && !rec_r && cnt.done;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;
    assign retain_active = (state_r == ADPS_RET);
    // No arbitration: the peer host must avoid same-address clashes

    // Direction stays low across the whole select-low write pulse
    sequence wr_pulse_s;
        !mem_sel_n && !mem_rd_wr_n;
    endsequence
    addr_stable_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!mem_rd_wr_n || !mem_sel_n) |-> $stable(mem_addr) || $past(mem_rd_wr_n && mem_sel_n))
        else $error("address moved during write");
    no_clash_a: assert property (@(posedge clk) disable iff (sys_rst)
        !port_data_bus_oe_n |-> mem_oe_n && !mem_rd_wr_n)
        else $error("data driven while device may drive");
    sel_late_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(mem_rd_wr_n) |-> mem_sel_n)
        else $error("select fell before direction");
    wr_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(!mem_sel_n && !mem_rd_wr_n) |-> wr_pulse_s [*2])
        else $error("write pulse too short");
    rd_oe_a: assert property (@(posedge clk) disable iff (sys_rst)
        !mem_oe_n |-> !mem_sel_n && mem_rd_wr_n)
        else $error("output enable outside read");
    rd_rsp_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(!mem_oe_n) |-> ##[3:8] rsp_valid)
        else $error("read response late");
    ret_desel_a: assert property (@(posedge clk) disable iff (sys_rst)
        retain_active |-> mem_sel_n && port_data_bus_oe_n)
        else $error("selected during retention");
    rec_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(retain_active) |-> !req_ready [*2])
        else $error("no recovery after retention");
    wr_tail_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(mem_sel_n) && !mem_rd_wr_n |-> !req_ready ##1 !req_ready)
        else $error("peer delay not honoured");
    // Write data held for the whole pulse; read answer is a single pulse
    wr_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        !port_data_bus_oe_n && !$past(port_data_bus_oe_n) |-> $stable(port_data_bus_out))
        else $error("write data moved while driven");
    rsp_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        rsp_valid |=> !rsp_valid)
        else $error("read answer longer than one cycle");
endmodule : adps_host
`default_nettype wire

// File: rtl/adps_timer.sv
// Down counter that times each phase of a memory cycle
`default_nettype none
module adps_timer (
    input wire logic clk,
    input wire logic sys_rst,
    adps_cnt_if.tmr cnt
);
    logic [3:0] cnt_r;
    // Load wins over counting so back-to-back phases stay exact
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 4'h0;
        end else if (cnt.load) begin
            cnt_r <= cnt.value;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // Done reads only the count: the sequencer's load is decoded from it
    assign cnt.done = (cnt_r == 4'h0);
endmodule : adps_timer
`default_nettype wire

// File: test/adps_host_test.sv
// Self-checking bench for the dual-port memory host controller
`include "adps_defines.svh"
`default_nettype none
module adps_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic sys_rst = 1;
    logic req_valid = 0;
    logic req_write = 0;
    logic [11:0] req_addr = 12'h000;
    logic [7:0] req_wdata = 8'h00;
    logic retain_req = 0;
    logic [11:0] b_addr = 12'h000;
    logic req_ready, retain_active, rsp_valid, sel_n, rd_wr_n, oe_n, bus_oe_n, a_drive;
    logic [7:0] rsp_rdata, bus_out, a_dout, b_dout;
    logic [11:0] mem_addr, prev_addr;
    wire logic [7:0] bus_in;
    int fails = 0;
    int total_checks = 0;
    // Wire level from both drivers
    assign bus_in = !bus_oe_n ? bus_out : a_dout;
    adps_host dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .retain_req(retain_req), .retain_active(retain_active),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_sel_n(sel_n),
        .mem_rd_wr_n(rd_wr_n), .mem_oe_n(oe_n), .mem_addr(mem_addr),
        .port_data_bus_in(bus_in), .port_data_bus_out(bus_out),
        .port_data_bus_oe_n(bus_oe_n));
    adps_mem_model mem (.a_sel_n(sel_n), .a_rd_wr_n(rd_wr_n), .a_oe_n(oe_n),
        .a_addr(mem_addr), .a_din(bus_in), .a_dout(a_dout), .a_drive(a_drive),
        .b_addr(b_addr), .b_dout(b_dout));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic bad(input string msg);
        fails++;
        $display("BAD %0t %s", $time, msg);
    endtask : bad
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) bad("bit mismatch");
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) bad("byte mismatch");
    endtask : chk_byte
    task automatic chk_int(input int got, input int exp);
        total_checks++;
        if (got != exp) bad("count mismatch");
    endtask : chk_int
    // Wire monitors: no contention, no address move inside a write
    always @(negedge clk) begin
        if (bus_oe_n === 1'b0 && a_drive === 1'b1) bad("bus contention");
        if (sel_n === 1'b0 && rd_wr_n === 1'b0 && mem_addr !== prev_addr) begin
            bad("address moved in write");
        end
        prev_addr = mem_addr;
    end
    // Request held at the falling edge, taken at the next rising edge
    task automatic do_req(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n >= 50) bad("ready never came");
        req_valid = 1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 0;
    endtask : do_req
    task automatic do_write(input logic [11:0] a, input logic [7:0] d);
        b_addr = a;
        do_req(1, a, d);
        while (req_ready !== 1'b1) @(negedge clk);
        // Peer must already see the byte when the controller is free again
        chk_byte(b_dout, d);
    endtask : do_write
    task automatic do_read(input logic [11:0] a, input logic [7:0] exp);
        int n;
        do_req(0, a, 8'h00);
        n = 1;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        // Read time plus two sync cycles, one settling cycle, one registered answer
        chk_int(n, `ADPS_RD_CYC + 4);
        chk_byte(rsp_rdata, exp);
    endtask : do_read
    task automatic t_reset;
        chk_bit(sel_n, 1);
        chk_bit(bus_oe_n, 1);
        chk_bit(oe_n, 1);
        chk_bit(rd_wr_n, 1);
        chk_bit(rsp_valid, 0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rw;
        do_write(12'h000, 8'h11);
        do_write(12'hfff, 8'hc3);
        do_write(12'h000, 8'h5a);
        do_write(12'h7a5, 8'hff);
        do_read(12'h000, 8'h5a);
        do_read(12'hfff, 8'hc3);
        do_read(12'h7a5, 8'hff);
        $display("test read write done");
    endtask : t_rw
    task automatic t_retain;
        retain_req = 1;
        @(negedge clk);
        @(negedge clk);
        chk_bit(retain_active, 1);
        chk_bit(sel_n, 1);
        chk_bit(req_ready, 0);
        retain_req = 0;
        @(negedge clk);
        chk_bit(req_ready, 0);
        do_read(12'hfff, 8'hc3);
        $display("test retention done");
    endtask : t_retain
    task automatic results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 0;
        t_reset();
        t_rw();
        t_retain();
        results();
    end
    // Whole run is under a hundred cycles
    initial begin
        #100000;
        bad("timeout");
        results();
    end
endmodule : adps_host_test
`default_nettype wire

// File: test/adps_mem_model.sv
// Behavioural model of the dual-port memory: port a faces the host, port b reads
`default_nettype none
module adps_mem_model (
    input wire logic a_sel_n,
    input wire logic a_rd_wr_n,
    input wire logic a_oe_n,
    input wire logic [11:0] a_addr,
    input wire logic [7:0] a_din,
    output logic [7:0] a_dout,
    output logic a_drive,
    input wire logic [11:0] b_addr,
    output logic [7:0] b_dout
);
    timeunit 1ns;
    timeprecision 1ps;
    // One shared array, no arbitration between ports
    logic [7:0] mem [0:4095];
    logic [7:0] din_dly;
    // Data seen 1 ns late, so the closing edge never stores the released bus
    assign #1 din_dly = a_din;
    // Store over the overlap of select and direction low; output control ignored
    always @* begin
        if (!a_sel_n && !a_rd_wr_n) begin
            mem[a_addr] = din_dly;
        end
    end
    // Drive only when selected, reading and output enabled; also floats while writing
    assign a_drive = !a_sel_n && a_rd_wr_n && !a_oe_n;
    // Floating pins show inverted data, so stale values never look valid
    assign #20 a_dout = a_drive ? mem[a_addr] : ~mem[a_addr];
    // Peer port sees stored data after the port-to-port delay
    assign #30 b_dout = mem[b_addr];
endmodule : adps_mem_model
`default_nettype wire
